// ==== logic/tlb_inval_map.vh ====
// Register offsets, field positions, operation codes and reset values of the invalidate block.
`ifndef TLB_INVAL_MAP_VH
`define TLB_INVAL_MAP_VH
// Global register offsets.
`define OFS_CTRL 12'h000
`define OFS_STATUS 12'h004
`define OFS_CACHED_MAP 12'h008
`define OFS_GLOBAL_INVAL_BASE 12'h040
`define OFS_GLOBAL_INVAL_LAST 12'h068
`define OFS_GSYNC_TRIG_SEC 12'h080
`define OFS_GSYNC_STATE_SEC 12'h084
`define OFS_GSYNC_TRIG_NS 12'h088
`define OFS_GSYNC_STATE_NS 12'h08c
// Context bank region: base, stride is 0x40, and word offsets inside a bank.
`define CTX_REGION_SEL 4'h1
`define CTX_WORD_SYNC_TRIG 4'h8
`define CTX_WORD_SYNC_STATE 4'h9
// Field positions.
`define CTRL_HINT_LSB 0
`define STATUS_QCOUNT_LSB 0
`define STATUS_OVF_BIT 8
`define STATUS_INFLIGHT_LSB 16
`define SYNC_ACTIVE_BIT 0
`define DATA_PAGE_LSB 12
// Reset values.
`define CTRL_RESET 4'h0
// Operation codes; 0 to 7 are the context bank forms in offset order.
`define OP_CTX_ALL 5'h00
`define OP_CTX_ASID 5'h01
`define OP_CTX_VA 5'h02
`define OP_CTX_VAA 5'h03
`define OP_CTX_VAA_LEAF 5'h04
`define OP_CTX_VA_LEAF 5'h05
`define OP_CTX_IPA 5'h06
`define OP_CTX_IPA_LEAF 5'h07
`define OP_SEC_ALL 5'h08
`define OP_MON_ALL 5'h09
`define OP_HYP_ALL 5'h0a
`define OP_GUEST_ALL 5'h0b
`define OP_MON_VA_LEAF 5'h0c
`define OP_MON_VA 5'h0d
`define OP_HYP_VA 5'h0e
`define OP_HYP_VA_WIDE 5'h0f
`define OP_HYP_VA_WIDE_LEAF 5'h10
`define OP_VMID 5'h11
`define OP_VMID_S1 5'h12
`define OP_FLUSH_ALL 5'h1f
// Translation regimes carried by cached entries.
`define REGIME_GUEST 2'h0
`define REGIME_HYP 2'h1
`define REGIME_SEC 2'h2
`define REGIME_MON 2'h3
`endif

// ==== logic/tlb_invalidate_sync.v ====
// TLB invalidate queue, cached entry store and sync tracking behind an AHB-Lite slave.
//
// Our own choices: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tlb_inval_map.vh"
module tlb_invalidate_sync (
  // Clock and reset.
  input wire core_clk,
  input wire rst,
  // AHB-Lite slave.
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  // Broadcast maintenance from the message transport.
  input wire bcast_valid,
  input wire [4:0] bcast_op,
  input wire [1:0] bcast_ctx,
  input wire [31:0] bcast_data,
  output wire bcast_ready,
  // Entry fill from the table walker.
  input wire fill_valid,
  input wire [2:0] fill_idx,
  input wire fill_ext_fault,
  input wire fill_xlat_fault,
  input wire fill_af_fault,
  input wire [1:0] fill_ctx,
  input wire [1:0] fill_regime,
  input wire [7:0] fill_vmid,
  input wire [7:0] fill_asid,
  input wire fill_global,
  input wire [19:0] fill_page,
  input wire [1:0] fill_page_size,
  input wire fill_has_s1,
  input wire fill_has_s2,
  input wire fill_leaf,
  // Translated transaction tracking.
  input wire txn_start,
  input wire txn_done,
  // Cached entry state.
  output reg [7:0] cached_valid
);

  // Processing states.
  localparam ST_IDLE = 2'h0;
  localparam ST_DRAIN = 2'h1;

  // Page compare mask from the size of the page an entry was splintered from.
  function [19:0] page_mask;
    input [1:0] psz;
    begin
      case (psz)
        2'h0: page_mask = 20'hfffff;
        2'h1: page_mask = 20'hffff0;
        2'h2: page_mask = 20'hffe00;
        default: page_mask = 20'h00000;
      endcase
    end
  endfunction

  // Ticket order compare that survives counter wrap: true once done has reached target.
  function ticket_reached;
    input [7:0] done;
    input [7:0] target;
    reg [7:0] diff;
    begin
      diff = target - done;
      ticket_reached = (diff == 8'h00) || diff[7];
    end
  endfunction

  // AHB data phase capture.
  reg dp_write_reg;
  reg [11:0] dp_addr_reg;
  wire addr_phase = hsel && htrans[1] && hready;

  // The slave never stalls, so invalidate writes are taken at full bus rate.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always @(posedge core_clk) begin
    if (rst) begin
      dp_write_reg <= 1'b0;
      dp_addr_reg <= 12'h000;
    end else begin
      dp_write_reg <= addr_phase && hwrite;
      dp_addr_reg <= haddr;
    end
  end

  // Write decode in the data phase.
  wire in_ctx = (dp_addr_reg[11:8] == `CTX_REGION_SEL);
  wire [1:0] wr_ctx = dp_addr_reg[7:6];
  wire [3:0] ctx_word = dp_addr_reg[5:2];
  wire wr_ctx_inval = dp_write_reg && in_ctx && !ctx_word[3];
  wire wr_ctx_sync = dp_write_reg && in_ctx && (ctx_word == `CTX_WORD_SYNC_TRIG);
  wire wr_glb_inval = dp_write_reg && (dp_addr_reg >= `OFS_GLOBAL_INVAL_BASE) &&
    (dp_addr_reg <= `OFS_GLOBAL_INVAL_LAST);
  wire [11:0] glb_rel = dp_addr_reg - `OFS_GLOBAL_INVAL_BASE;
  wire wr_gsync_sec = dp_write_reg && (dp_addr_reg == `OFS_GSYNC_TRIG_SEC);
  wire wr_gsync_ns = dp_write_reg && (dp_addr_reg == `OFS_GSYNC_TRIG_NS);
  wire wr_ctrl = dp_write_reg && (dp_addr_reg == `OFS_CTRL);
  wire bus_inval = wr_ctx_inval || wr_glb_inval;

  // Control register holding the private ASID hint per bank.
  reg [3:0] hint_reg;
  always @(posedge core_clk) begin
    if (rst) begin
      hint_reg <= `CTRL_RESET;
    end else if (wr_ctrl) begin
      hint_reg <= hwdata[`CTRL_HINT_LSB+3:`CTRL_HINT_LSB];
    end
  end

  // Broadcasts yield to a bus invalidate write in the same cycle; ASID-naming ones may be dropped.
  assign bcast_ready = !bus_inval;
  wire bcast_names_asid = (bcast_op == `OP_CTX_ASID) || (bcast_op == `OP_CTX_VA) ||
    (bcast_op == `OP_CTX_VA_LEAF);
  wire bcast_drop = bcast_names_asid && hint_reg[bcast_ctx];
  wire bcast_push = bcast_valid && bcast_ready && !bcast_drop;

  // Selected push source.
  wire push = bus_inval || bcast_push;
  wire [4:0] push_op = wr_ctx_inval ? {2'b00, ctx_word[2:0]} :
    wr_glb_inval ? (`OP_SEC_ALL + glb_rel[6:2]) : bcast_op;
  wire [1:0] push_ctx = bus_inval ? wr_ctx : bcast_ctx;
  wire [31:0] push_data = bus_inval ? hwdata : bcast_data;

  // Posted operation queue; each operation carries the ticket it was issued with.
  reg [46:0] q_mem [0:3];
  reg [1:0] q_wr_reg;
  reg [1:0] q_rd_reg;
  reg [2:0] q_count_reg;
  reg [7:0] issued_reg;
  reg [7:0] done_reg;
  reg ovf_reg;
  reg [7:0] ovf_ticket_reg;
  reg [1:0] state_reg;
  reg [7:0] proc_ticket_reg;
  reg [7:0] drain_reg;
  reg [7:0] inflight_reg;
  integer i;

  wire [7:0] next_ticket = issued_reg + 8'h01;
  // Once the queue is full, later posts fold into one flush so no write is ever refused.
  wire push_to_ovf = push && (ovf_reg || (q_count_reg == 3'h4));
  wire push_to_q = push && !push_to_ovf;
  wire q_empty = (q_count_reg == 3'h0);
  wire start_q = (state_reg == ST_IDLE) && !q_empty;
  wire start_ovf = (state_reg == ST_IDLE) && q_empty && ovf_reg;
  // A post that joins a pending flush reuses its ticket, so few tickets are ever open
  // and a long flood of posts cannot fool the wrap-safe compare of sync targets.
  wire fold_post = push_to_ovf && ovf_reg && !start_ovf;
  wire new_ticket = push && !fold_post;
  wire [46:0] q_head = q_mem[q_rd_reg];
  wire [4:0] cur_op = start_ovf ? `OP_FLUSH_ALL : q_head[46:42];
  wire [1:0] cur_ctx = q_head[41:40];
  wire [31:0] cur_data = q_head[39:8];
  wire in_flight_change = txn_start ^ txn_done;

  // Queue, ticket and overflow bookkeeping.
  always @(posedge core_clk) begin
    if (rst) begin
      q_wr_reg <= 2'h0;
      q_rd_reg <= 2'h0;
      q_count_reg <= 3'h0;
      issued_reg <= 8'h00;
      ovf_reg <= 1'b0;
      ovf_ticket_reg <= 8'h00;
      for (i = 0; i < 4; i = i + 1) begin
        q_mem[i] <= 47'h0;
      end
    end else begin
      if (new_ticket) begin
        issued_reg <= next_ticket;
      end
      // Posting only records the operation; completion shows through a later sync.
      if (push_to_q) begin
        q_mem[q_wr_reg] <= {push_op, push_ctx, push_data, next_ticket};
        q_wr_reg <= q_wr_reg + 2'h1;
      end
      if (start_q) begin
        q_rd_reg <= q_rd_reg + 2'h1;
      end
      q_count_reg <= q_count_reg + {2'b00, push_to_q} - {2'b00, start_q};
      // A new overflow post wins over the flush start that clears the flag.
      if (push_to_ovf) begin
        ovf_reg <= 1'b1;
        if (!fold_post) begin
          ovf_ticket_reg <= next_ticket;
        end
      end else if (start_ovf) begin
        ovf_reg <= 1'b0;
      end
    end
  end

  // Per-entry kill decision for the operation being applied.
  reg [7:0] kill_vec;
  reg [1:0] e_ctx [0:7];
  reg [1:0] e_regime [0:7];
  reg [7:0] e_vmid [0:7];
  reg [7:0] e_asid [0:7];
  reg [7:0] e_global;
  reg [19:0] e_page [0:7];
  reg [1:0] e_psz [0:7];
  reg [7:0] e_s1;
  reg [7:0] e_s2;
  reg [7:0] e_leaf;
  reg va_hit;
  reg asid_hit;
  reg ctx_hit;
  integer k;

  always @* begin
    kill_vec = 8'h00;
    va_hit = 1'b0;
    asid_hit = 1'b0;
    ctx_hit = 1'b0;
    for (k = 0; k < 8; k = k + 1) begin
      // Page match against the original page covers every splintered piece.
      va_hit = ((e_page[k] ^ cur_data[31:`DATA_PAGE_LSB]) & page_mask(e_psz[k])) ==
        20'h00000;
      asid_hit = (e_asid[k] == cur_data[7:0]);
      ctx_hit = (e_ctx[k] == cur_ctx) && e_s1[k];
      case (cur_op)
        // Bank stage 1 forms hit only entries carrying that bank's stage 1 data.
        `OP_CTX_ALL: kill_vec[k] = ctx_hit;
        `OP_CTX_ASID: kill_vec[k] = ctx_hit && asid_hit;
        `OP_CTX_VA: kill_vec[k] = ctx_hit && va_hit && (asid_hit || e_global[k]);
        `OP_CTX_VAA: kill_vec[k] = ctx_hit && va_hit;
        `OP_CTX_VAA_LEAF: kill_vec[k] = ctx_hit && va_hit && e_leaf[k];
        `OP_CTX_VA_LEAF: kill_vec[k] = ctx_hit && va_hit && e_leaf[k] &&
          (asid_hit || e_global[k]);
        // IPA forms hit stage 2 or combined entries of the bank.
        `OP_CTX_IPA: kill_vec[k] = (e_ctx[k] == cur_ctx) && e_s2[k] &&
          (va_hit || e_s1[k]);
        `OP_CTX_IPA_LEAF: kill_vec[k] = (e_ctx[k] == cur_ctx) && e_s2[k] &&
          (va_hit || e_s1[k]) && e_leaf[k];
        // Global forms act on stage 1 information of their regime, except guest-all and the VMID form, which also hit stage 2 entries.
        `OP_SEC_ALL: kill_vec[k] = e_s1[k] && (e_regime[k] == `REGIME_SEC);
        `OP_MON_ALL: kill_vec[k] = e_s1[k] && (e_regime[k] == `REGIME_MON);
        `OP_HYP_ALL: kill_vec[k] = e_s1[k] && (e_regime[k] == `REGIME_HYP);
        `OP_GUEST_ALL: kill_vec[k] = (e_regime[k] == `REGIME_GUEST);
        `OP_MON_VA_LEAF: kill_vec[k] = e_s1[k] && (e_regime[k] == `REGIME_MON) &&
          va_hit && e_leaf[k];
        `OP_MON_VA: kill_vec[k] = e_s1[k] && (e_regime[k] == `REGIME_MON) && va_hit;
        `OP_HYP_VA: kill_vec[k] = e_s1[k] && (e_regime[k] == `REGIME_HYP) && va_hit;
        `OP_HYP_VA_WIDE: kill_vec[k] = e_s1[k] && (e_regime[k] == `REGIME_HYP) && va_hit;
        `OP_HYP_VA_WIDE_LEAF: kill_vec[k] = e_s1[k] && (e_regime[k] == `REGIME_HYP) &&
          va_hit && e_leaf[k];
        `OP_VMID: kill_vec[k] = (e_regime[k] == `REGIME_GUEST) &&
          (e_vmid[k] == cur_data[7:0]);
        `OP_VMID_S1: kill_vec[k] = e_s1[k] && (e_regime[k] == `REGIME_GUEST) &&
          (e_vmid[k] == cur_data[7:0]);
        `OP_FLUSH_ALL: kill_vec[k] = 1'b1;
        default: kill_vec[k] = 1'b0;
      endcase
    end
  end

  // Entry store; the discard of an operation is applied in the cycle it leaves the queue.
  wire fill_ok = fill_valid && !fill_ext_fault && !fill_xlat_fault && !fill_af_fault;
  wire applying = start_q || start_ovf;
  integer j;

  always @(posedge core_clk) begin
    if (rst) begin
      cached_valid <= 8'h00;
      e_global <= 8'h00;
      e_s1 <= 8'h00;
      e_s2 <= 8'h00;
      e_leaf <= 8'h00;
      for (j = 0; j < 8; j = j + 1) begin
        e_ctx[j] <= 2'h0;
        e_regime[j] <= 2'h0;
        e_vmid[j] <= 8'h00;
        e_asid[j] <= 8'h00;
        e_page[j] <= 20'h00000;
        e_psz[j] <= 2'h0;
      end
    end else begin
      for (j = 0; j < 8; j = j + 1) begin
        // A fill that arrives while its slot is discarded still lands afterwards.
        if (fill_ok && (fill_idx == j[2:0])) begin
          cached_valid[j] <= 1'b1;
          e_ctx[j] <= fill_ctx;
          e_regime[j] <= fill_regime;
          e_vmid[j] <= fill_vmid;
          e_asid[j] <= fill_asid;
          e_global[j] <= fill_global;
          e_page[j] <= fill_page;
          e_psz[j] <= fill_page_size;
          e_s1[j] <= fill_has_s1;
          e_s2[j] <= fill_has_s2;
          e_leaf[j] <= fill_leaf;
        end else if (applying && kill_vec[j]) begin
          cached_valid[j] <= 1'b0;
        end
      end
    end
  end

  // In-flight count; a nested stage 1 descriptor fetch is reported as one transaction.
  always @(posedge core_clk) begin
    if (rst) begin
      inflight_reg <= 8'h00;
    end else if (in_flight_change && txn_start) begin
      inflight_reg <= inflight_reg + 8'h01;
    end else if (in_flight_change && (inflight_reg != 8'h00)) begin
      inflight_reg <= inflight_reg - 8'h01;
    end
  end

  // Completion: after the discard, wait for every transaction older than the discard.
  // Completions are assumed to retire oldest first, so counting them down suffices.
  always @(posedge core_clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      proc_ticket_reg <= 8'h00;
      drain_reg <= 8'h00;
      done_reg <= 8'h00;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (applying) begin
            proc_ticket_reg <= start_ovf ? ovf_ticket_reg : q_head[7:0];
            drain_reg <= (txn_done && (inflight_reg != 8'h00)) ? inflight_reg - 8'h01 :
              inflight_reg;
            state_reg <= ST_DRAIN;
          end
        end
        ST_DRAIN: begin
          if (drain_reg == 8'h00) begin
            done_reg <= proc_ticket_reg;
            state_reg <= ST_IDLE;
          end else if (txn_done) begin
            drain_reg <= drain_reg - 8'h01;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Sync targets. Because operations retire in issue order, a bank sync also
  // completes older operations of other banks; that is a stronger guarantee.
  reg [7:0] ctx_target [0:3];
  reg [3:0] ctx_active_reg;
  reg [7:0] gsync_target_sec_reg;
  reg [7:0] gsync_target_ns_reg;
  reg gsync_active_sec_reg;
  reg gsync_active_ns_reg;
  wire [7:0] sync_ticket = new_ticket ? next_ticket : issued_reg;
  integer c;

  always @(posedge core_clk) begin
    if (rst) begin
      ctx_active_reg <= 4'h0;
      gsync_target_sec_reg <= 8'h00;
      gsync_target_ns_reg <= 8'h00;
      gsync_active_sec_reg <= 1'b0;
      gsync_active_ns_reg <= 1'b0;
      for (c = 0; c < 4; c = c + 1) begin
        ctx_target[c] <= 8'h00;
      end
    end else begin
      for (c = 0; c < 4; c = c + 1) begin
        // A new sync write wins over completion of the previous one.
        if (wr_ctx_sync && (wr_ctx == c[1:0])) begin
          ctx_target[c] <= issued_reg;
          ctx_active_reg[c] <= 1'b1;
        end else if (ticket_reached(done_reg, ctx_target[c])) begin
          ctx_active_reg[c] <= 1'b0;
        end
      end
      // Global syncs wait on every ticket issued, bank or global, before the write.
      if (wr_gsync_sec) begin
        gsync_target_sec_reg <= sync_ticket;
        gsync_active_sec_reg <= 1'b1;
      end else if (ticket_reached(done_reg, gsync_target_sec_reg)) begin
        gsync_active_sec_reg <= 1'b0;
      end
      if (wr_gsync_ns) begin
        gsync_target_ns_reg <= sync_ticket;
        gsync_active_ns_reg <= 1'b1;
      end else if (ticket_reached(done_reg, gsync_target_ns_reg)) begin
        gsync_active_ns_reg <= 1'b0;
      end
    end
  end

  // Read data is prepared in the address phase so reads take no wait state.
  reg [31:0] rd_next;
  wire [1:0] rd_ctx = haddr[7:6];
  always @* begin
    rd_next = 32'h00000000;
    if (haddr[11:8] == `CTX_REGION_SEL) begin
      if (haddr[5:2] == `CTX_WORD_SYNC_STATE) begin
        rd_next[`SYNC_ACTIVE_BIT] = ctx_active_reg[rd_ctx];
      end
    end else begin
      case (haddr)
        `OFS_CTRL: rd_next[`CTRL_HINT_LSB+3:`CTRL_HINT_LSB] = hint_reg;
        `OFS_STATUS: begin
          rd_next[`STATUS_QCOUNT_LSB+2:`STATUS_QCOUNT_LSB] = q_count_reg;
          rd_next[`STATUS_OVF_BIT] = ovf_reg;
          rd_next[`STATUS_INFLIGHT_LSB+7:`STATUS_INFLIGHT_LSB] = inflight_reg;
        end
        `OFS_CACHED_MAP: rd_next[7:0] = cached_valid;
        `OFS_GSYNC_STATE_SEC: rd_next[`SYNC_ACTIVE_BIT] = gsync_active_sec_reg;
        `OFS_GSYNC_STATE_NS: rd_next[`SYNC_ACTIVE_BIT] = gsync_active_ns_reg;
        default: rd_next = 32'h00000000;
      endcase
    end
  end

  always @(posedge core_clk) begin
    if (rst) begin
      hrdata <= 32'h00000000;
    end else if (addr_phase && !hwrite) begin
      hrdata <= rd_next;
    end
  end

endmodule // tlb_invalidate_sync
`default_nettype wire

// ==== test/tlb_invalidate_sync_assertions.sv ====
// Concurrent checks on the ports of the invalidate block.
`timescale 1ns/1ps
`default_nettype none
module tlb_invalidate_sync_assertions (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Register bus.
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Broadcast, fill and entry state.
  input wire logic bcast_ready,
  input wire logic fill_valid,
  input wire logic [2:0] fill_idx,
  input wire logic fill_ext_fault,
  input wire logic fill_xlat_fault,
  input wire logic fill_af_fault,
  input wire logic [7:0] cached_valid
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // Address phase qualifiers as the slave samples them.
  wire logic rd_ap = hsel && htrans[1] && hready && !hwrite;
  wire logic wr_ap = hsel && htrans[1] && hready && hwrite;
  wire logic bad = fill_ext_fault || fill_xlat_fault || fill_af_fault;
  // A read of the hole between the global and bank regions.
  sequence s_rd_hole;
    rd_ap && haddr == 12'h0fc;
  endsequence
  // The data phase that follows a write address phase.
  sequence s_wr_data;
    $past(wr_ap);
  endsequence
  chk_never_stalls: assert property (hreadyout && !hresp)
    else $error("bus slave stalled or answered with an error");
  chk_bcast_stall_cause: assert property (!bcast_ready |-> s_wr_data)
    else $error("broadcast stalled outside a write data phase");
  chk_fill_sets: assert property (fill_valid && !bad |=> cached_valid[$past(fill_idx)])
    else $error("clean fill did not set its entry");
  chk_fault_not_cached: assert property (
    fill_valid && bad && !cached_valid[fill_idx] |=> !cached_valid[$past(fill_idx)])
    else $error("faulting fill was cached");
  chk_entry_rise_cause: assert property (
    (cached_valid & ~$past(cached_valid)) != 8'h00 |-> $past(fill_valid && !bad))
    else $error("entry became valid without a clean fill");
  chk_reset_idle: assert property (@(posedge core_clk) disable iff (1'b0)
    rst |=> cached_valid == 8'h00 && hrdata == 32'h0 && bcast_ready)
    else $error("outputs not idle after reset");
  chk_rdata_holds: assert property (!$past(rd_ap) |-> $stable(hrdata))
    else $error("read data changed without a read");
  chk_hole_reads_zero: assert property (s_rd_hole |=> hrdata == 32'h0)
    else $error("unmapped read returned nonzero");
endmodule // tlb_invalidate_sync_assertions
bind tlb_invalidate_sync tlb_invalidate_sync_assertions i_tlb_invalidate_sync_assertions (
  .core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .bcast_ready(bcast_ready), .fill_valid(fill_valid), .fill_idx(fill_idx),
  .fill_ext_fault(fill_ext_fault), .fill_xlat_fault(fill_xlat_fault),
  .fill_af_fault(fill_af_fault), .cached_valid(cached_valid));
`default_nettype wire

// ==== test/tb_top.sv ====
// Directed register-level testbench of the invalidate block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic core_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, bcast_valid = 1'b0;
  logic [11:0] haddr = 12'h0;
  logic [1:0] htrans = 2'h0, bcast_ctx = 2'h0, fill_ctx = 2'h0, fill_regime = 2'h0;
  logic [1:0] fill_page_size = 2'h0;
  logic [31:0] hwdata = 32'h0, bcast_data = 32'h0, q;
  logic [4:0] bcast_op = 5'h00;
  logic fill_valid = 1'b0, fill_ext_fault = 1'b0, fill_xlat_fault = 1'b0, fill_af_fault = 1'b0;
  logic fill_has_s1 = 1'b0, fill_has_s2 = 1'b0, txn_start = 1'b0, txn_done = 1'b0;
  logic [2:0] fill_idx = 3'h0;
  logic [7:0] fill_vmid = 8'h00, fill_asid = 8'h00, cached_valid;
  logic [19:0] fill_page = 20'h0;
  wire logic [31:0] hrdata;
  wire logic hreadyout, hresp, bcast_ready;
  int n_mismatch = 0, check_count = 0;
  // The clock runs at 200 MHz.
  initial begin
    forever #2.5 core_clk = ~core_clk;
  end
  // The single slave's ready is the bus ready.
  tlb_invalidate_sync i_tlb_invalidate_sync (.core_clk(core_clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .bcast_valid(bcast_valid), .bcast_op(bcast_op), .bcast_ctx(bcast_ctx),
    .bcast_data(bcast_data), .bcast_ready(bcast_ready), .fill_valid(fill_valid),
    .fill_idx(fill_idx), .fill_ext_fault(fill_ext_fault), .fill_xlat_fault(fill_xlat_fault),
    .fill_af_fault(fill_af_fault), .fill_ctx(fill_ctx), .fill_regime(fill_regime),
    .fill_vmid(fill_vmid), .fill_asid(fill_asid), .fill_global(1'b0), .fill_page(fill_page),
    .fill_page_size(fill_page_size), .fill_has_s1(fill_has_s1), .fill_has_s2(fill_has_s2),
    .fill_leaf(1'b1), .txn_start(txn_start), .txn_done(txn_done), .cached_valid(cached_valid));
  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop;
    $display("Checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Four-state compare that counts and reports.
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Waits for a rising edge with ready high; a hung bus ends the run.
  task automatic wait_ready;
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    if (hreadyout !== 1'b1) begin
      n_mismatch++;
      report_and_stop();
    end
  endtask
  // One single word transfer: address phase held to ready, then data phase held to ready.
  task automatic bus_op(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    {hsel, haddr, hwrite, htrans} <= {1'b1, a, w, 2'h2};
    wait_ready();
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    q = hrdata;
  endtask
  // Sync trigger, then polls the active bit until it reads zero.
  task automatic sync(input logic [11:0] trig);
    int n;
    n = 0;
    bus_op(1'b1, trig, 32'h1);
    q = 32'h1;
    while (q[0] !== 1'b0 && n < 40) begin
      bus_op(1'b0, trig + 12'h4, 32'h0);
      n++;
    end
    check("sync_state", 32'h0, q & 32'h1);
    if (q[0] !== 1'b0) report_and_stop();
  endtask
  // One fill pulse; the entry's ASID and VMID equal its index.
  task automatic fill(input logic [2:0] i, input logic [1:0] c, input logic [1:0] r,
    input logic [19:0] p, input logic s1, input logic s2, input logic [2:0] f);
    @(posedge core_clk);
    {fill_valid, fill_idx, fill_ctx, fill_regime, fill_page, fill_has_s1, fill_has_s2,
      fill_ext_fault, fill_xlat_fault, fill_af_fault, fill_asid, fill_vmid} <=
      {1'b1, i, c, r, p, s1, s2, f, 5'h0, i, 5'h0, i};
    @(posedge core_clk);
    fill_valid <= 1'b0;
  endtask
  // Main sequence.
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    bus_op(1'b0, 12'h000, 32'h0);
    check("ctrl_reset", 32'h0, q);
    bus_op(1'b1, 12'h0fc, 32'hffffffff);
    bus_op(1'b0, 12'h0fc, 32'h0);
    check("unmapped", 32'h0, q);
    fill(3'h0, 2'h0, 2'h0, 20'h10, 1'b1, 1'b0, 3'h0);
    fill(3'h1, 2'h1, 2'h0, 20'h11, 1'b1, 1'b0, 3'h0);
    fill(3'h2, 2'h0, 2'h0, 20'h20, 1'b0, 1'b1, 3'h0);
    fill(3'h3, 2'h2, 2'h1, 20'h30, 1'b1, 1'b0, 3'h0);
    fill(3'h4, 2'h2, 2'h0, 20'h40, 1'b1, 1'b0, 3'h0);
    fill(3'h6, 2'h3, 2'h0, 20'h50, 1'b0, 1'b1, 3'h0);
    fill(3'h7, 2'h3, 2'h0, 20'h60, 1'b1, 1'b0, 3'h0);
    for (int f = 0; f < 3; f++) fill(3'h5, 2'h1, 2'h0, 20'h70, 1'b1, 1'b0, 3'h1 << f);
    check("cached_fill", 32'hdf, {24'h0, cached_valid});
    // Hint on bank 2 drops its ASID broadcast; bank 1 still honours one.
    bus_op(1'b1, 12'h000, 32'h4);
    bus_op(1'b0, 12'h000, 32'h0);
    check("ctrl", 32'h4, q);
    for (int b = 1; b < 3; b++) begin
      @(posedge core_clk);
      {bcast_valid, bcast_op, bcast_ctx, bcast_data} <= {1'b1, 5'h01, b[1:0], 32'(b * b)};
      @(posedge core_clk);
      check("bcast_ready", 32'h1, {31'h0, bcast_ready});
      bcast_valid <= 1'b0;
    end
    sync(12'h088);
    check("cached_hint", 32'h10, {24'h0, cached_valid & 8'h12});
    // Bank sync stays active while an older transaction is in flight.
    @(posedge core_clk);
    txn_start <= 1'b1;
    @(posedge core_clk);
    txn_start <= 1'b0;
    bus_op(1'b0, 12'h004, 32'h0);
    check("status", 32'h00010000, q);
    bus_op(1'b1, 12'h100, 32'h0);
    bus_op(1'b1, 12'h120, 32'h1);
    bus_op(1'b0, 12'h124, 32'h0);
    check("ctx_active", 32'h1, q & 32'h1);
    @(posedge core_clk);
    txn_done <= 1'b1;
    @(posedge core_clk);
    txn_done <= 1'b0;
    sync(12'h120);
    check("cached_ctx_all", 32'h10, {24'h0, cached_valid & 8'h11});
    bus_op(1'b1, 12'h1d8, 32'h00050000);
    sync(12'h1e0);
    check("cached_ipa", 32'h80, {24'h0, cached_valid & 8'hc0});
    bus_op(1'b1, 12'h048, 32'h0);
    sync(12'h088);
    check("cached_hyp", 32'h10, {24'h0, cached_valid & 8'h18});
    // An entry splintered from a 64K page goes when another address in that page is hit.
    fill_page_size <= 2'h1;
    fill(3'h1, 2'h1, 2'h0, 20'h11, 1'b1, 1'b0, 3'h0);
    bus_op(1'b1, 12'h148, 32'h0001f001);
    sync(12'h160);
    check("cached_splinter", 32'h0, {24'h0, cached_valid & 8'h02});
    // All eight bank forms in a row, the software keeping the number of posts bounded.
    fill(3'h1, 2'h1, 2'h0, 20'h11, 1'b1, 1'b0, 3'h0);
    for (int k = 0; k < 8; k++) bus_op(1'b1, 12'h140 + 12'(k * 4), 32'h00011001);
    sync(12'h160);
    check("cached_bank1", 32'h0, {24'h0, cached_valid & 8'h02});
    // All eleven global forms back to back; guest-all also clears stage 2 entries.
    for (int k = 0; k < 11; k++) bus_op(1'b1, 12'h040 + 12'(k * 4), 32'h0);
    sync(12'h080);
    check("cached_global", 32'h0, {24'h0, cached_valid});
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
